// ===== rtl/pdc_engine.sv
// pixel draw command engine: apb registers, command sequencer, pixel datapath
//
// Added by the designer: the APB slave port and the register addresses.
`default_nettype none
// Functional notes
// - 04h fills rectangles until command replaced
// - rectangle pixels use rectangle colour
// - start point then end point per rectangle
// - layer flag set: command layer field used
// - layer flag clear: point layer used
// - settings latched only at command start
// - colours masked to active depth bits
// - 05h expands one bit per pixel window
// - text commands end after window filled
// - set bit foreground; clear bit background if enabled
// - 06h same with run-length coded enables
// - 07h address then colour, writes pixel
// - colour right-aligned in, left-aligned to memory
// - 08h address plus packed memory-format word
// - 09h writes fixed colour per address
// - 0Ah reads pixel, pushes right-aligned colour
// - 0Bh returns old pixel, writes new colour
// - writing command code byte starts command
// - 24-bit packed data spans word boundaries
module pdc_engine (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] inWord,
  input wire logic inValid,
  output logic inReady,
  output logic [31:0] outWord,
  output logic outValid,
  input wire logic outReady,
  output logic memReq,
  output logic memWrite,
  output logic memPacked,
  output logic [3:0] memLayer,
  output logic [11:0] memX,
  output logic [11:0] memY,
  output logic [31:0] memWdata,
  input wire logic [31:0] memRdata,
  input wire logic memAck,
  output logic busy
);
  pdc_walk_if wk();

  pdc_walker walker (
    .clk(clk),
    .sys_rst(sys_rst),
    .wk(wk.walk)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction

  // software copies
  logic [31:0] regCmd;
  logic [4:0] regDraw;
  logic [31:0] regRect;
  logic [31:0] regFg;
  logic [31:0] regBg;
  logic [31:0] regPix;
  logic [31:0] regMin;
  logic [31:0] regMax;
  logic [2:0] regDepth;
  logic pend;
  logic [7:0] pendCode;

  // copies in force for the running command
  logic [7:0] code;
  logic [31:0] sRect;
  logic [31:0] sFg;
  logic [31:0] sBg;
  logic [31:0] sPix;
  logic sUlay;
  logic [3:0] sLay;
  logic [5:0] sBits;

  pdc_pkg::pdc_state_e st;
  pdc_pkg::pdc_coord_t ptX;
  pdc_pkg::pdc_coord_t ptY;
  logic [3:0] rectLayer;
  logic [31:0] newCol;
  logic [31:0] bitSh;
  logic [pdc_pkg::RLE_CNT_W-1:0] bitCnt;
  logic runVal;

  // apb decode
  wire logic apbWr = psel && penable && pwrite;
  wire logic hitCmd = paddr == pdc_pkg::ADDR_CMD;
  wire logic hitDraw = paddr == pdc_pkg::ADDR_DRAW;
  wire logic hitRect = paddr == pdc_pkg::ADDR_RECT;
  wire logic hitFg = paddr == pdc_pkg::ADDR_FG;
  wire logic hitBg = paddr == pdc_pkg::ADDR_BG;
  wire logic hitPix = paddr == pdc_pkg::ADDR_PIX;
  wire logic hitWmin = paddr == pdc_pkg::ADDR_WMIN;
  wire logic hitWmax = paddr == pdc_pkg::ADDR_WMAX;
  wire logic hitDepth = paddr == pdc_pkg::ADDR_DEPTH;
  wire logic hitStat = paddr == pdc_pkg::ADDR_STAT;
  wire logic mapped = hitCmd || hitDraw || hitRect || hitFg || hitBg || hitPix || hitWmin || hitWmax
    || hitDepth || hitStat;
  wire logic cmdWr = apbWr && hitCmd && pstrb[0];
  wire logic [31:0] drawWord = merge({27'h0, regDraw}, pwdata, pstrb);
  wire logic [31:0] depthWord = merge({29'h0, regDepth}, pwdata, pstrb);

  wire logic [31:0] statWord = {16'h0, code, 6'h0, pend, busy};
  wire logic [31:0] rdMux =
    hitCmd ? regCmd :
    hitDraw ? {27'h0, regDraw} :
    hitRect ? regRect :
    hitFg ? regFg :
    hitBg ? regBg :
    hitPix ? regPix :
    hitWmin ? regMin :
    hitWmax ? regMax :
    hitDepth ? {29'h0, regDepth} :
    hitStat ? statWord : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // command decode
  wire logic pendTxt = pendCode == pdc_pkg::CMD_TXT_PLAIN || pendCode == pdc_pkg::CMD_TXT_PACKED;
  wire logic pendKnown = pendCode >= pdc_pkg::CMD_RECT && pendCode <= pdc_pkg::CMD_SWAP_PIX;
  wire logic takeable = st == pdc_pkg::ST_IDLE || st == pdc_pkg::ST_ADDR || st == pdc_pkg::ST_BITS;
  wire logic takeNow = pend && takeable;
  wire logic isRect = code == pdc_pkg::CMD_RECT;
  wire logic isPacked = code == pdc_pkg::CMD_TXT_PACKED;
  wire logic isText = code == pdc_pkg::CMD_TXT_PLAIN || isPacked;
  wire logic isWord = code == pdc_pkg::CMD_PUT_WORD;
  wire logic isFill = code == pdc_pkg::CMD_FILL_FIX;
  wire logic isGet = code == pdc_pkg::CMD_GET_PIX;
  wire logic isSwap = code == pdc_pkg::CMD_SWAP_PIX;

  // input words
  wire logic fetchState = st == pdc_pkg::ST_ADDR || st == pdc_pkg::ST_DATA || st == pdc_pkg::ST_BITS;
  assign inReady = fetchState && !takeNow;
  wire logic inTake = inValid && inReady;
  wire logic [3:0] wLayer = {inWord[31:30], inWord[15:14]};
  wire pdc_pkg::pdc_coord_t wX = inWord[pdc_pkg::PT_X_LSB +: pdc_pkg::COORD_W];
  wire pdc_pkg::pdc_coord_t wY = inWord[pdc_pkg::PT_Y_LSB +: pdc_pkg::COORD_W];
  wire pdc_pkg::pdc_coord_t minX = regMin[pdc_pkg::PT_X_LSB +: pdc_pkg::COORD_W];
  wire pdc_pkg::pdc_coord_t minY = regMin[pdc_pkg::PT_Y_LSB +: pdc_pkg::COORD_W];
  wire pdc_pkg::pdc_coord_t maxX = regMax[pdc_pkg::PT_X_LSB +: pdc_pkg::COORD_W];
  wire pdc_pkg::pdc_coord_t maxY = regMax[pdc_pkg::PT_Y_LSB +: pdc_pkg::COORD_W];

  // colour alignment, depth taken from the command's copy
  wire logic [31:0] colMask = (32'h0000_0001 << sBits) - 32'h0000_0001;
  wire logic [5:0] alignSh = pdc_pkg::ALIGN_TOP - sBits;
  wire logic [31:0] inAligned = (inWord & colMask) << alignSh;
  wire logic [31:0] pixAligned = (sPix & colMask) << alignSh;
  wire logic [31:0] rdAligned = (memRdata >> alignSh) & colMask;

  // raster drawing
  wire logic haveBit = bitCnt != '0;
  wire logic curBit = isPacked ? runVal : bitSh[31];
  wire logic wantWr = isRect || curBit || sBg[pdc_pkg::BG_EN_BIT];
  wire logic [31:0] drawCol = isRect ? sRect : (curBit ? sFg : sBg);
  wire logic [31:0] drawAligned = (drawCol & colMask) << alignSh;
  wire logic inWalk = st == pdc_pkg::ST_WALK;
  wire logic walkIssue = inWalk && (isRect || haveBit) && wantWr;
  wire logic walkSkip = inWalk && isText && haveBit && !wantWr;
  wire logic walkAck = st == pdc_pkg::ST_MEMW && memAck && (isRect || isText);
  wire logic adv = walkSkip || walkAck;
  wire logic outDone = outValid && outReady;
  wire logic rectStart = st == pdc_pkg::ST_DATA && inTake && isRect;
  wire logic txtStart = takeNow && pendTxt;

  // corners may come in any order
  assign wk.start = rectStart || txtStart;
  assign wk.step = adv && !wk.last;
  assign wk.xLo = rectStart ? (ptX < wX ? ptX : wX) : minX;
  assign wk.xHi = rectStart ? (ptX < wX ? wX : ptX) : maxX;
  assign wk.yLo = rectStart ? (ptY < wY ? ptY : wY) : minY;
  assign wk.yHi = rectStart ? (ptY < wY ? wY : ptY) : maxY;

  assign busy = st != pdc_pkg::ST_IDLE;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      regCmd <= pdc_pkg::RST_WORD;
      regDraw <= '0;
      regRect <= pdc_pkg::RST_WORD;
      regFg <= pdc_pkg::RST_WORD;
      regBg <= pdc_pkg::RST_WORD;
      regPix <= pdc_pkg::RST_WORD;
      regMin <= pdc_pkg::RST_WORD;
      regMax <= pdc_pkg::RST_WORD;
      regDepth <= pdc_pkg::RST_DEPTH;
      prdata <= pdc_pkg::RST_WORD;
    end
    else
    begin
      if (apbWr && hitCmd)
        regCmd <= merge(regCmd, pwdata, pstrb);
      if (apbWr && hitDraw)
        regDraw <= drawWord[4:0];
      if (apbWr && hitRect)
        regRect <= merge(regRect, pwdata, pstrb);
      if (apbWr && hitFg)
        regFg <= merge(regFg, pwdata, pstrb);
      if (apbWr && hitBg)
        regBg <= merge(regBg, pwdata, pstrb);
      if (apbWr && hitPix)
        regPix <= merge(regPix, pwdata, pstrb);
      if (apbWr && hitWmin)
        regMin <= merge(regMin, pwdata, pstrb);
      if (apbWr && hitWmax)
        regMax <= merge(regMax, pwdata, pstrb);
      if (apbWr && hitDepth)
        regDepth <= depthWord[2:0];
      // read data captured in the setup cycle, zero wait states
      if (psel && !penable)
        prdata <= rdMux;
    end
  end

  // a new code written in the cycle it is taken stays pending
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pend <= 1'b0;
      pendCode <= '0;
    end
    else
    begin
      pend <= cmdWr || (pend && !takeNow);
      if (cmdWr)
        pendCode <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= pdc_pkg::ST_IDLE;
      code <= '0;
      sRect <= '0;
      sFg <= '0;
      sBg <= '0;
      sPix <= '0;
      sUlay <= 1'b0;
      sLay <= '0;
      sBits <= '0;
      ptX <= '0;
      ptY <= '0;
      rectLayer <= '0;
      newCol <= '0;
      bitSh <= '0;
      bitCnt <= '0;
      runVal <= 1'b0;
      outWord <= '0;
      outValid <= 1'b0;
      memReq <= 1'b0;
      memWrite <= 1'b0;
      memPacked <= 1'b0;
      memLayer <= '0;
      memX <= '0;
      memY <= '0;
      memWdata <= '0;
    end
    else
    begin
      if (memAck)
        memReq <= 1'b0;
      if (outDone)
        outValid <= 1'b0;
      if (adv && isText)
      begin
        bitCnt <= bitCnt - 1'b1;
        bitSh <= {bitSh[30:0], 1'b0};
      end
      if (takeNow)
      begin
        // takeable states never have a memory access or result open
        code <= pendCode;
        sRect <= regRect;
        sFg <= regFg;
        sBg <= regBg;
        sPix <= regPix;
        sUlay <= regDraw[pdc_pkg::DRAW_ULAY_BIT];
        sLay <= regDraw[pdc_pkg::DRAW_LAY_LSB +: pdc_pkg::LAYER_W];
        sBits <= pdc_pkg::depth_bits(regDepth);
        bitCnt <= '0;
        st <= !pendKnown ? pdc_pkg::ST_IDLE : (pendTxt ? pdc_pkg::ST_BITS : pdc_pkg::ST_ADDR);
      end
      else
        case (st)
          pdc_pkg::ST_ADDR:
            if (inTake)
            begin
              memLayer <= wLayer;
              memX <= wX;
              memY <= wY;
              ptX <= wX;
              ptY <= wY;
              memPacked <= 1'b0;
              if (isFill)
              begin
                memWdata <= pixAligned;
                memWrite <= 1'b1;
                memReq <= 1'b1;
                st <= pdc_pkg::ST_MEMW;
              end
              else if (isGet)
              begin
                memWrite <= 1'b0;
                memReq <= 1'b1;
                st <= pdc_pkg::ST_MEMR;
              end
              else
                st <= pdc_pkg::ST_DATA;
            end
          pdc_pkg::ST_DATA:
            if (inTake)
            begin
              if (isRect)
              begin
                rectLayer <= sUlay ? sLay : wLayer;
                st <= pdc_pkg::ST_WALK;
              end
              else if (isSwap)
              begin
                newCol <= inAligned;
                memWrite <= 1'b0;
                memReq <= 1'b1;
                st <= pdc_pkg::ST_MEMR;
              end
              else
              begin
                // packed words go out untouched, memory unpacks and wraps 24-bit pixels
                memWdata <= isWord ? inWord : inAligned;
                memPacked <= isWord;
                memWrite <= 1'b1;
                memReq <= 1'b1;
                st <= pdc_pkg::ST_MEMW;
              end
            end
          pdc_pkg::ST_BITS:
            if (inTake)
            begin
              bitSh <= inWord;
              runVal <= inWord[pdc_pkg::RLE_VAL_BIT];
              bitCnt <= isPacked ? inWord[pdc_pkg::RLE_CNT_W-1:0] : pdc_pkg::WORD_BITS;
              st <= pdc_pkg::ST_WALK;
            end
          pdc_pkg::ST_WALK:
            if (walkIssue)
            begin
              memLayer <= isRect ? rectLayer : sLay;
              memX <= wk.x;
              memY <= wk.y;
              memWdata <= drawAligned;
              memPacked <= 1'b0;
              memWrite <= 1'b1;
              memReq <= 1'b1;
              st <= pdc_pkg::ST_MEMW;
            end
            else if (walkSkip && wk.last)
              st <= pdc_pkg::ST_IDLE;
            else if (isText && !haveBit)
              st <= pdc_pkg::ST_BITS;
          pdc_pkg::ST_MEMW:
            if (memAck)
            begin
              if (!walkAck)
                st <= pdc_pkg::ST_ADDR;
              else if (!wk.last)
                st <= pdc_pkg::ST_WALK;
              else
                st <= isRect ? pdc_pkg::ST_ADDR : pdc_pkg::ST_IDLE;
            end
          pdc_pkg::ST_MEMR:
            if (memAck)
            begin
              outWord <= rdAligned;
              outValid <= 1'b1;
              st <= pdc_pkg::ST_OUT;
            end
          pdc_pkg::ST_OUT:
            // result held until the output side takes it
            if (outDone)
            begin
              if (isSwap)
              begin
                memWdata <= newCol;
                memWrite <= 1'b1;
                memReq <= 1'b1;
                st <= pdc_pkg::ST_MEMW;
              end
              else
                st <= pdc_pkg::ST_ADDR;
            end
          default:
            st <= pdc_pkg::ST_IDLE;
        endcase
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pdc_pkg.sv
// shared constants, types and helpers of the pixel draw command engine
`default_nettype none
package pdc_pkg;
  localparam int COORD_W = 12;
  localparam int LAYER_W = 4;
  localparam int ADDR_W = 12;
  localparam int PT_X_LSB = 16;
  localparam int PT_Y_LSB = 0;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_DRAW = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_RECT = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_FG = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_BG = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_PIX = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_WMIN = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_WMAX = 12'h01C;
  localparam logic [ADDR_W-1:0] ADDR_DEPTH = 12'h020;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h024;
  localparam logic [7:0] CMD_RECT = 8'h04;
  localparam logic [7:0] CMD_TXT_PLAIN = 8'h05;
  localparam logic [7:0] CMD_TXT_PACKED = 8'h06;
  localparam logic [7:0] CMD_PUT_PIX = 8'h07;
  localparam logic [7:0] CMD_PUT_WORD = 8'h08;
  localparam logic [7:0] CMD_FILL_FIX = 8'h09;
  localparam logic [7:0] CMD_GET_PIX = 8'h0A;
  localparam logic [7:0] CMD_SWAP_PIX = 8'h0B;
  localparam int DRAW_ULAY_BIT = 0;
  localparam int DRAW_LAY_LSB = 1;
  localparam int BG_EN_BIT = 31;
  localparam int RLE_VAL_BIT = 31;
  localparam int RLE_CNT_W = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_CODE_LSB = 8;
  localparam logic [RLE_CNT_W-1:0] WORD_BITS = 16'h0020;
  localparam logic [5:0] ALIGN_TOP = 6'h20;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0] RST_DEPTH = 3'h3;
  typedef logic [COORD_W-1:0] pdc_coord_t;
  typedef enum {ST_IDLE, ST_ADDR, ST_DATA, ST_BITS, ST_WALK, ST_MEMW, ST_MEMR, ST_OUT} pdc_state_e;
  function automatic logic [5:0] depth_bits(input logic [2:0] c);
    case (c)
      3'h0: depth_bits = 6'h01;
      3'h1: depth_bits = 6'h02;
      3'h2: depth_bits = 6'h04;
      3'h3: depth_bits = 6'h08;
      3'h4: depth_bits = 6'h10;
      3'h5: depth_bits = 6'h18;
      default: depth_bits = 6'h08;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== rtl/pdc_walk_if.sv
// raster walk control between the command engine and the walker
`default_nettype none
interface pdc_walk_if;
  logic start;
  logic step;
  pdc_pkg::pdc_coord_t xLo;
  pdc_pkg::pdc_coord_t yLo;
  pdc_pkg::pdc_coord_t xHi;
  pdc_pkg::pdc_coord_t yHi;
  pdc_pkg::pdc_coord_t x;
  pdc_pkg::pdc_coord_t y;
  logic last;
  modport ctrl(output start, step, xLo, yLo, xHi, yHi, input x, y, last);
  modport walk(input start, step, xLo, yLo, xHi, yHi, output x, y, last);
endinterface
`default_nettype wire

// ===== rtl/pdc_walker.sv
// row-by-row walker over a rectangular pixel area
`default_nettype none
module pdc_walker (
  input wire logic clk,
  input wire logic sys_rst,
  pdc_walk_if.walk wk
);
  pdc_pkg::pdc_coord_t xFirst;
  pdc_pkg::pdc_coord_t xLast;
  pdc_pkg::pdc_coord_t yLast;
  pdc_pkg::pdc_coord_t curX;
  pdc_pkg::pdc_coord_t curY;
  wire logic rowEnd = curX == xLast;

  assign wk.x = curX;
  assign wk.y = curY;
  assign wk.last = rowEnd && (curY == yLast);

  // bounds are latched at start so the engine may change its muxes freely
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      xFirst <= '0;
      xLast <= '0;
      yLast <= '0;
      curX <= '0;
      curY <= '0;
    end
    else if (wk.start)
    begin
      xFirst <= wk.xLo;
      xLast <= wk.xHi;
      yLast <= wk.yHi;
      curX <= wk.xLo;
      curY <= wk.yLo;
    end
    else if (wk.step)
    begin
      if (rowEnd)
      begin
        curX <= xFirst;
        curY <= curY + 1'b1;
      end
      else
        curX <= curX + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/pdc_engine_props.sv
// port assertions of the pixel draw command engine
`default_nettype none
module pdc_engine_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic inValid,
  input wire logic inReady,
  input wire logic [31:0] outWord,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic memPacked,
  input wire logic [11:0] memX,
  input wire logic [11:0] memY,
  input wire logic memAck,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic cmdWr = psel && penable && pwrite && paddr == 12'h000;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_start; cmdWr && pwdata[7:0] inside {[8'h04:8'h0B]} |-> ##[1:3] busy; endproperty
  a_start: assert property (p_start) else $error("command write did not start the engine");
  property p_memhold; memReq && !memAck |=> memReq && $stable({memX, memY, memWrite}); endproperty
  a_memhold: assert property (p_memhold) else $error("memory request dropped or changed early");
  property p_ack; memAck |=> !memReq; endproperty
  a_ack: assert property (p_ack) else $error("memory request still high after acknowledge");
  property p_outhold; outValid && !outReady |=> outValid && $stable(outWord); endproperty
  a_outhold: assert property (p_outhold) else $error("result lost while output full");
  property p_outpause; outValid && !outReady |-> !$rose(memReq); endproperty
  a_outpause: assert property (p_outpause) else $error("memory access while output full");
  property p_inbusy; inReady |-> busy; endproperty
  a_inbusy: assert property (p_inbusy) else $error("input taken with no command running");
  property p_packed; memReq && memPacked |-> memWrite; endproperty
  a_packed: assert property (p_packed) else $error("packed access is not a write");
  property p_errmap; psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h024); endproperty
  a_errmap: assert property (p_errmap) else $error("error response wrong for address");
  c_packed: cover property (memReq && memPacked);
  c_outfull: cover property (outValid && !outReady);
  c_install: cover property (busy && !inValid);
endmodule
bind pdc_engine pdc_engine_props u_pdc_engine_props (.clk(clk), .sys_rst(sys_rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pslverr(pslverr), .inValid(inValid),
  .inReady(inReady), .outWord(outWord), .outValid(outValid), .outReady(outReady), .memReq(memReq),
  .memWrite(memWrite), .memPacked(memPacked), .memX(memX), .memY(memY), .memAck(memAck), .busy(busy));
`default_nettype wire

// ===== tb/pdc_host_model.sv
// host side model: input fifo head and output fifo sink
`default_nettype none
module pdc_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [31:0] inWord,
  output logic inValid,
  input wire logic inReady,
  input wire logic [31:0] outWord,
  input wire logic outValid,
  output logic outReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q[$];
  logic [31:0] got[$];
  logic slow = 1'b0;
  logic go;
  int hd = 0;
  function automatic void push(input logic [31:0] x);
    q.push_back(x);
  endfunction
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      inValid <= 1'b0;
      inWord <= 32'h0;
      outReady <= 1'b0;
    end
    else
    begin
      if (inValid && inReady)
        hd = hd + 1;
      // head word held until taken
      if (!inValid || inReady)
      begin
        go = hd < q.size() && (!slow || $urandom_range(1, 0) == 1);
        inValid <= go;
        inWord <= go ? q[hd] : ~inWord;
      end
      outReady <= !slow || $urandom_range(1, 0) == 1;
      if (outValid && outReady)
        got.push_back(outWord);
    end
  end
endmodule
`default_nettype wire

// ===== tb/pixel_draw_command_engine_test.sv
// self-checking bench of the pixel draw command engine
`default_nettype none
module pixel_draw_command_engine_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, memAck = 1'b0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, memRdata = 32'h0, prdata, inWord, outWord, memWdata, r, w, fg, bg;
  logic [31:0] c[4];
  logic [27:0] a[4], k;
  logic [3:0] memLayer;
  logic [11:0] memX, memY;
  logic pready, pslverr, inValid, inReady, outValid, outReady, memReq, memWrite, memPacked, busy;
  logic [31:0] vm[logic [27:0]];
  logic [31:0] pk[logic [27:0]];
  int num_errors = 0, num_checks = 0, cyc = 0, nWr = 0, bpp = 8;
  int bppTab[8] = '{1, 2, 4, 8, 16, 24, 8, 8};
  logic [2:0] depths[3] = '{3'h1, 3'h4, 3'h5};
  wire logic [27:0] key = {memLayer, memX, memY};
  pdc_engine u_pdc_engine (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pstrb(4'hF), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inWord(inWord), .inValid(inValid), .inReady(inReady), .outWord(outWord), .outValid(outValid),
    .outReady(outReady), .memReq(memReq), .memWrite(memWrite), .memPacked(memPacked), .memLayer(memLayer),
    .memX(memX), .memY(memY), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .busy(busy));
  pdc_host_model u_pdc_host_model (.clk(clk), .sys_rst(sys_rst), .inWord(inWord), .inValid(inValid),
    .inReady(inReady), .outWord(outWord), .outValid(outValid), .outReady(outReady));
  always #12.5 clk = ~clk;
  // video memory: random ack delay, idle read data toggles
  always @(posedge clk)
    if (memReq && !memAck && $urandom_range(1, 0) == 1)
    begin
      memAck <= 1'b1;
      memRdata <= vm.exists(key) ? vm[key] : 32'h0;
      if (memWrite && memPacked)
        pk[key] = memWdata;
      else if (memWrite)
        vm[key] = memWdata;
      nWr += memWrite;
    end
    else
    begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
    end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end
  function automatic logic [31:0] msk(input logic [31:0] v);
    return v & ((32'h1 << bpp) - 32'h1);
  endfunction
  function automatic logic [31:0] al(input logic [31:0] v);
    return msk(v) << (32 - bpp);
  endfunction
  function automatic logic [31:0] pt(input logic [27:0] p);
    return {p[27:26], 2'h0, p[23:12], p[25:24], 2'h0, p[11:0]};
  endfunction
  task complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task apb(input logic [11:0] ad, input logic wr, input logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] ad, input logic [31:0] d);
    apb(ad, 1'b1, d, r, e);
  endtask
  task put(input logic [31:0] x);
    u_pdc_host_model.push(x);
  endtask
  task sync(input int n, input int g);
    while (nWr < n || u_pdc_host_model.got.size() < g)
      @(posedge clk);
  endtask
  initial
  begin
    void'($urandom(32'hA001));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    apb(12'h040, 1'b0, 32'h0, r, e);
    chk("unmapped", 32'h0, r);
    chk("slverr", 32'h1, {31'h0, e});
    foreach (depths[j])
    begin
      wr(pdc_pkg::ADDR_DEPTH, {29'h0, depths[j]});
      apb(pdc_pkg::ADDR_DEPTH, 1'b0, 0, r, e);
      chk("depth", {29'h0, depths[j]}, r);
      bpp = bppTab[depths[j]];
      nWr = 0;
      wr(pdc_pkg::ADDR_CMD, {24'h0, pdc_pkg::CMD_PUT_PIX});
      for (int i = 0; i < 4; i++)
      begin
        a[i] = $urandom;
        c[i] = $urandom;
        put(pt(a[i]));
        put(c[i]);
      end
      sync(4, 0);
      for (int i = 0; i < 4; i++)
        chk("put", al(c[i]), vm[a[i]]);
      u_pdc_host_model.got.delete();
      wr(pdc_pkg::ADDR_CMD, {24'h0, pdc_pkg::CMD_GET_PIX});
      for (int i = 0; i < 4; i++)
        put(pt(a[i]));
      sync(4, 4);
      for (int i = 0; i < 4; i++)
        chk("get", msk(c[i]), u_pdc_host_model.got[i]);
      w = $urandom;
      nWr = 0;
      wr(pdc_pkg::ADDR_PIX, w);
      wr(pdc_pkg::ADDR_CMD, {24'h0, pdc_pkg::CMD_FILL_FIX});
      put(pt(a[0]));
      sync(1, 0);
      // a new colour written mid-command must wait for the next command
      wr(pdc_pkg::ADDR_PIX, ~w);
      put(pt(a[1]));
      sync(2, 0);
      for (int i = 0; i < 2; i++)
        chk("fill", al(w), vm[a[i]]);
      u_pdc_host_model.slow = 1'b1;
      u_pdc_host_model.got.delete();
      nWr = 0;
      wr(pdc_pkg::ADDR_CMD, {24'h0, pdc_pkg::CMD_SWAP_PIX});
      for (int i = 0; i < 2; i++)
      begin
        put(pt(a[i]));
        put(c[i + 2]);
      end
      sync(2, 2);
      for (int i = 0; i < 2; i++)
      begin
        chk("swap old", msk(w), u_pdc_host_model.got[i]);
        chk("swap new", al(c[i + 2]), vm[a[i]]);
      end
      wr(pdc_pkg::ADDR_CMD, {24'h0, pdc_pkg::CMD_PUT_WORD});
      put(pt(a[3]));
      put(w);
      sync(3, 2);
      chk("word", w, pk[a[3]]);
    end
    for (int f = 0; f < 2; f++)
    begin
      vm.delete();
      nWr = 0;
      w = $urandom;
      wr(pdc_pkg::ADDR_RECT, w);
      wr(pdc_pkg::ADDR_DRAW, {27'h0, 4'h9, f[0]});
      wr(pdc_pkg::ADDR_CMD, {24'h0, pdc_pkg::CMD_RECT});
      wr(pdc_pkg::ADDR_RECT, ~w);
      put(pt(28'h0005003));
      put(pt(28'h6003004));
      put(pt(28'h0010001));
      put(pt(28'h6010001));
      sync(7, 0);
      for (int i = 0; i < 7; i++)
      begin
        k = i < 6 ? {4'h6, 12'(3 + i % 3), 12'(3 + i / 3)} : 28'h6010001;
        if (f != 0)
          k[27:24] = 4'h9;
        chk("rect", al(w), vm[k]);
      end
    end
    for (int t = 0; t < 3; t++)
    begin
      vm.delete();
      nWr = 0;
      fg = $urandom;
      bg = $urandom;
      w = t == 2 ? 32'hFFC0_0000 : $urandom;
      wr(pdc_pkg::ADDR_WMIN, 32'h0);
      wr(pdc_pkg::ADDR_WMAX, 32'h0007_0003);
      wr(pdc_pkg::ADDR_FG, fg);
      wr(pdc_pkg::ADDR_BG, {t != 0, bg[30:0]});
      wr(pdc_pkg::ADDR_CMD, {24'h0, t == 2 ? pdc_pkg::CMD_TXT_PACKED : pdc_pkg::CMD_TXT_PLAIN});
      if (t == 2)
      begin
        put(32'h8000_000A);
        put(32'h0);
        put(32'h0000_0016);
      end
      else
        put(w);
      sync(t == 0 ? $countones(w) : 32, 0);
      for (int i = 0; i < 40 && busy !== 1'b0; i++)
        @(posedge clk);
      chk("end", 32'h0, {31'h0, busy});
      for (int i = 0; i < 32; i++)
      begin
        k = {4'h9, 12'(i % 8), 12'(i / 8)};
        if (w[31 - i])
          chk("fg", al(fg), vm[k]);
        else if (t != 0)
          chk("bg", al(bg), vm[k]);
        else
          chk("skip", 32'h0, 32'(vm.exists(k)));
      end
    end
    complete_run();
  end
endmodule
`default_nettype wire
